//--- src/tai_defines.vh
`ifndef TAI_DEFINES_VH
`define TAI_DEFINES_VH

// Register pointers
`define TAI_P_STAT1 8'h02
`define TAI_P_CFG_RD 8'h03
`define TAI_P_CFG_WR 8'h09
`define TAI_P_ONESHOT 8'h0F
`define TAI_P_HYST 8'h21
`define TAI_P_CONSEC 8'h22
`define TAI_P_STAT2 8'h23
`define TAI_P_HI0 8'h30
`define TAI_P_LO0 8'h34
`define TAI_P_FS_LOC 8'h38
`define TAI_P_FS_REM 8'h39
`define TAI_P_RES0 8'h40

// Configuration and consecutive-alarm bit positions
`define TAI_CFG_MASK_ALL 7
`define TAI_CFG_STANDBY 6
`define TAI_CFG_SEC_MODE 5
`define TAI_CFG_MASK_R1 1
`define TAI_CFG_MASK_R2 0
`define TAI_CONSEC_MASK_LOC 5

// Status bit positions
`define TAI_ST_BUSY 7
`define TAI_ST_HI 6
`define TAI_ST_LO 5
`define TAI_ST1_R1_HI 4
`define TAI_ST1_R1_LO 3
`define TAI_ST_OPEN 2
`define TAI_ST1_R1_FS 1
`define TAI_ST_FS 0
`define TAI_ST2_R2_HI 4
`define TAI_ST2_R2_LO 3
`define TAI_ST2_R2_FS 1
`define TAI_ST_CLR_MASK 8'h7F

// Reset values
`define TAI_RST_CFG 8'h00
`define TAI_RST_CONSEC 8'h00
`define TAI_RST_HYST 8'h0A
`define TAI_RST_FS 8'h55
`define TAI_RST_HI 8'h55
`define TAI_RST_LO 8'h00
`define TAI_RST_RD 8'h00

// Bus addresses
`define TAI_DEV_ADDR 7'h4C
`define TAI_ARA_ADDR 7'h0C

// Timing counts
`define TAI_CONV_PERIOD 100000

`endif

//--- src/tai_hyst_cmp.v
`timescale 1ns/1ps
// Over-limit comparator that releases at limit minus hysteresis
module tai_hyst_cmp #(
  parameter W = 8
) (
  input wire ref_clk,
  input wire srst,
  input wire update,
  input wire [W-1:0] temp,
  input wire [W-1:0] limit,
  input wire [W-1:0] hyst,
  output reg active_r
);
  wire [W:0] lim_x;
  wire [W:0] sum_x;

  // Widened so temp plus hysteresis cannot wrap
  assign lim_x = {1'b0, limit};
  assign sum_x = {1'b0, temp} + {1'b0, hyst};

  // Set above limit, release at or below limit minus hysteresis
  always @(posedge ref_clk) begin
    if (srst) begin
      active_r <= 1'b0;
    end else if (update) begin
      if (temp > limit) begin
        active_r <= 1'b1;
      end else if (active_r && sum_x <= lim_x) begin
        active_r <= 1'b0;
      end
    end
  end
endmodule // tai_hyst_cmp

//--- src/tai_alarm.v
`timescale 1ns/1ps
`include "tai_defines.vh"
module tai_alarm #(
  parameter CONV_PERIOD = `TAI_CONV_PERIOD,
  parameter CW = 20
) (
  input wire ref_clk,
  input wire srst,
  input wire smb_scl_in,
  input wire smb_sda_in,
  output reg smb_sda_out_r,
  output reg smb_sda_oe_r,
  input wire conv_done,
  input wire [7:0] conv_temp_loc,
  input wire [7:0] conv_temp_r1,
  input wire [7:0] conv_temp_r2,
  input wire r1_open_cmp,
  input wire r2_open_cmp,
  output reg conv_start_r,
  output reg conv_abort_r,
  output reg standby_r,
  output reg limit_alarm_out_r,
  output reg limit_alarm_oe_r,
  output reg failsafe_over_temp_out_r,
  output reg failsafe_over_temp_oe_r
);
  localparam S_IDLE = 7'h01;
  localparam S_ADDR = 7'h02;
  localparam S_PTR = 7'h04;
  localparam S_WDAT = 7'h08;
  localparam S_ACK = 7'h10;
  localparam S_RDAT = 7'h20;
  localparam S_RACK = 7'h40;
  localparam [31:0] PER_LAST_W = CONV_PERIOD - 1;
  localparam [CW-1:0] PER_LAST = PER_LAST_W[CW-1:0];

  reg [1:0] scl_q_r, sda_q_r;
  reg scl_d_r, sda_d_r;
  reg [6:0] st_r, ack_nxt_r;
  reg [3:0] cnt_r;
  reg [7:0] sh_r, tx_r, ptr_r, wr_data_r, rd_val_r, rd_byte;
  reg wr_stb_r, rd_stb_r, ara_r, rd_ara_r;
  reg [7:0] cfg_r, consec_r, hyst_r, fs_loc_r, fs_rem_r;
  reg [7:0] hi_lim_r [0:2];
  reg [7:0] lo_lim_r [0:2];
  reg [7:0] res_r [0:2];
  reg [7:0] stat1_r, stat2_r, set1, set2, clr1, clr2;
  reg [CW-1:0] per_cnt_r;
  reg busy_r, os_act_r, os_pend_r, eval_r, eval_d_r;
  reg [1:0] open_r;
  reg [2:0] hi_lvl_r, lo_lvl_r;
  reg alert_r, ara_served_r;
  wire [2:0] fs_act, sec_act, ch_mask;
  wire scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
  wire standby, tick, cond_now, stat_any;
  integer i, iw, ir, ic;

  // Two-flop synchronisers for the bus pins
  always @(posedge ref_clk) begin
    if (srst) begin
      scl_q_r <= 2'b11;
      sda_q_r <= 2'b11;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_q_r <= {scl_q_r[0], smb_scl_in};
      sda_q_r <= {sda_q_r[0], smb_sda_in};
      scl_d_r <= scl_q_r[1];
      sda_d_r <= sda_q_r[1];
    end
  end

  // Bus edge and condition detection on synchronised levels
  assign scl_s = scl_q_r[1];
  assign sda_s = sda_q_r[1];
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Read multiplexer; configuration readable only at its read pointer
  always @* begin
    rd_byte = `TAI_RST_RD;
    i = 0;
    if (ara_r) begin
      rd_byte = {`TAI_DEV_ADDR, 1'b1};
    end else begin
      case (ptr_r)
        `TAI_P_STAT1: rd_byte = {busy_r, stat1_r[6:0]};
        `TAI_P_STAT2: rd_byte = stat2_r;
        `TAI_P_CFG_RD: rd_byte = cfg_r;
        `TAI_P_CONSEC: rd_byte = consec_r;
        `TAI_P_HYST: rd_byte = hyst_r;
        `TAI_P_FS_LOC: rd_byte = fs_loc_r;
        `TAI_P_FS_REM: rd_byte = fs_rem_r;
        default: begin
          for (i = 0; i < 3; i = i + 1) begin
            if (ptr_r == `TAI_P_HI0 + i[7:0]) rd_byte = hi_lim_r[i];
            if (ptr_r == `TAI_P_LO0 + i[7:0]) rd_byte = lo_lim_r[i];
            if (ptr_r == `TAI_P_RES0 + i[7:0]) rd_byte = res_r[i];
          end
        end
      endcase
    end
  end

  // Serial slave; runs regardless of standby
  always @(posedge ref_clk) begin
    if (srst) begin
      st_r <= S_IDLE;
      ack_nxt_r <= S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      wr_data_r <= 8'h00;
      rd_val_r <= 8'h00;
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      ara_r <= 1'b0;
      rd_ara_r <= 1'b0;
      smb_sda_oe_r <= 1'b0;
      smb_sda_out_r <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      smb_sda_out_r <= 1'b0;
      if (bus_stop) begin
        st_r <= S_IDLE;
        smb_sda_oe_r <= 1'b0;
      end else if (bus_start) begin
        st_r <= S_ADDR;
        cnt_r <= 4'h0;
        smb_sda_oe_r <= 1'b0;
      end else begin
        case (st_r)
          S_ADDR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              if (sh_r[7:1] == `TAI_DEV_ADDR) begin
                smb_sda_oe_r <= 1'b1;
                st_r <= S_ACK;
                ack_nxt_r <= sh_r[0] ? S_RDAT : S_PTR;
                ara_r <= 1'b0;
              end else if (sh_r == {`TAI_ARA_ADDR, 1'b1} &&
                           limit_alarm_oe_r && !cfg_r[`TAI_CFG_SEC_MODE]) begin
                smb_sda_oe_r <= 1'b1;
                st_r <= S_ACK;
                ack_nxt_r <= S_RDAT;
                ara_r <= 1'b1;
              end else begin
                st_r <= S_IDLE;
              end
            end
          end
          S_PTR, S_WDAT: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              smb_sda_oe_r <= 1'b1;
              st_r <= S_ACK;
              ack_nxt_r <= S_WDAT;
              if (st_r == S_PTR) begin
                ptr_r <= sh_r;
              end else begin
                wr_data_r <= sh_r;
                wr_stb_r <= 1'b1;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              st_r <= ack_nxt_r;
              cnt_r <= 4'h0;
              if (ack_nxt_r == S_RDAT) begin
                tx_r <= rd_byte;
                smb_sda_oe_r <= ~rd_byte[7];
                rd_val_r <= rd_byte;
                rd_ara_r <= ara_r;
                rd_stb_r <= 1'b1;
              end else begin
                smb_sda_oe_r <= 1'b0;
              end
            end
          end
          S_RDAT: begin
            if (scl_rise) begin
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (cnt_r == 4'h8) begin
                smb_sda_oe_r <= 1'b0;
                st_r <= S_RACK;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                smb_sda_oe_r <= ~tx_r[6];
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                st_r <= S_IDLE;
              end else begin
                st_r <= S_ACK;
                ack_nxt_r <= S_RDAT;
              end
            end
          end
          S_IDLE: st_r <= S_IDLE;
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end

  // Host-writable registers; no standby gating on limits
  always @(posedge ref_clk) begin
    if (srst) begin
      cfg_r <= `TAI_RST_CFG;
      consec_r <= `TAI_RST_CONSEC;
      hyst_r <= `TAI_RST_HYST;
      fs_loc_r <= `TAI_RST_FS;
      fs_rem_r <= `TAI_RST_FS;
      for (iw = 0; iw < 3; iw = iw + 1) begin
        hi_lim_r[iw] <= `TAI_RST_HI;
        lo_lim_r[iw] <= `TAI_RST_LO;
      end
    end else if (wr_stb_r) begin
      case (ptr_r)
        `TAI_P_CFG_WR: cfg_r <= wr_data_r;
        `TAI_P_CONSEC: consec_r <= wr_data_r;
        `TAI_P_HYST: hyst_r <= wr_data_r;
        `TAI_P_FS_LOC: fs_loc_r <= wr_data_r;
        `TAI_P_FS_REM: fs_rem_r <= wr_data_r;
        default: begin
          for (iw = 0; iw < 3; iw = iw + 1) begin
            if (ptr_r == `TAI_P_HI0 + iw[7:0])
              hi_lim_r[iw] <= wr_data_r;
            if (ptr_r == `TAI_P_LO0 + iw[7:0])
              lo_lim_r[iw] <= wr_data_r;
          end
        end
      endcase
    end
  end

  assign standby = cfg_r[`TAI_CFG_STANDBY];
  assign tick = (per_cnt_r == PER_LAST);

  // Conversion scheduler, standby abort and one-shot
  always @(posedge ref_clk) begin
    if (srst) begin
      per_cnt_r <= {CW{1'b0}};
      busy_r <= 1'b0;
      os_act_r <= 1'b0;
      os_pend_r <= 1'b0;
      conv_start_r <= 1'b0;
      conv_abort_r <= 1'b0;
      eval_r <= 1'b0;
      eval_d_r <= 1'b0;
      open_r <= 2'b00;
      standby_r <= 1'b0;
      for (ir = 0; ir < 3; ir = ir + 1) begin
        res_r[ir] <= 8'h00;
      end
    end else begin
      conv_start_r <= 1'b0;
      conv_abort_r <= 1'b0;
      eval_r <= 1'b0;
      eval_d_r <= eval_r;
      standby_r <= standby;
      // Restarts from zero on leaving standby
      per_cnt_r <= (tick || standby) ? {CW{1'b0}} :
                   per_cnt_r + {{(CW-1){1'b0}}, 1'b1};
      if (wr_stb_r && ptr_r == `TAI_P_ONESHOT && standby) begin
        os_pend_r <= 1'b1;
      end else if (!standby) begin
        os_pend_r <= 1'b0;
      end
      if (busy_r) begin
        if (standby && !os_act_r) begin
          busy_r <= 1'b0;
          conv_abort_r <= 1'b1;
        end else if (conv_done) begin
          busy_r <= 1'b0;
          os_act_r <= 1'b0;
          eval_r <= 1'b1;
          res_r[0] <= conv_temp_loc;
          if (!open_r[0]) res_r[1] <= conv_temp_r1;
          if (!open_r[1]) res_r[2] <= conv_temp_r2;
        end
      end else if (os_pend_r && standby) begin
        busy_r <= 1'b1;
        os_act_r <= 1'b1;
        os_pend_r <= 1'b0;
        conv_start_r <= 1'b1;
        open_r <= {r2_open_cmp, r1_open_cmp};
      end else if (!standby && tick) begin
        busy_r <= 1'b1;
        conv_start_r <= 1'b1;
        open_r <= {r2_open_cmp, r1_open_cmp};
      end
    end
  end

  // Limit comparisons on the stored results
  always @(posedge ref_clk) begin
    if (srst) begin
      hi_lvl_r <= 3'b000;
      lo_lvl_r <= 3'b000;
    end else if (eval_r) begin
      for (ic = 0; ic < 3; ic = ic + 1) begin
        hi_lvl_r[ic] <= res_r[ic] > hi_lim_r[ic];
        lo_lvl_r[ic] <= res_r[ic] <= lo_lim_r[ic];
      end
    end
  end

  // Fail-safe and secondary comparators per channel
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ch
      tai_hyst_cmp #(.W(8)) u_fs (
        .ref_clk(ref_clk),
        .srst(srst),
        .update(eval_r),
        .temp(res_r[g]),
        .limit(g == 0 ? fs_loc_r : fs_rem_r),
        .hyst(hyst_r),
        .active_r(fs_act[g])
      );
      tai_hyst_cmp #(.W(8)) u_sec (
        .ref_clk(ref_clk),
        .srst(srst),
        .update(eval_r),
        .temp(res_r[g]),
        .limit(hi_lim_r[g]),
        .hyst(hyst_r),
        .active_r(sec_act[g])
      );
    end
  endgenerate

  // Status set and read-clear; a set in the clear cycle survives
  always @* begin
    set1 = 8'h00;
    set2 = 8'h00;
    set1[`TAI_ST_OPEN] = conv_start_r & open_r[0];
    set2[`TAI_ST_OPEN] = conv_start_r & open_r[1];
    set1[`TAI_ST_HI] = eval_d_r & hi_lvl_r[0];
    set1[`TAI_ST_LO] = eval_d_r & lo_lvl_r[0];
    set1[`TAI_ST1_R1_HI] = eval_d_r & hi_lvl_r[1];
    set1[`TAI_ST1_R1_LO] = eval_d_r & lo_lvl_r[1];
    set1[`TAI_ST_FS] = eval_d_r & fs_act[0];
    set1[`TAI_ST1_R1_FS] = eval_d_r & fs_act[1];
    set2[`TAI_ST2_R2_HI] = eval_d_r & hi_lvl_r[2];
    set2[`TAI_ST2_R2_LO] = eval_d_r & lo_lvl_r[2];
    set2[`TAI_ST2_R2_FS] = eval_d_r & fs_act[2];
    clr1 = 8'h00;
    clr2 = 8'h00;
    if (rd_stb_r && !rd_ara_r && ptr_r == `TAI_P_STAT1)
      clr1 = rd_val_r & `TAI_ST_CLR_MASK;
    if (rd_stb_r && !rd_ara_r && ptr_r == `TAI_P_STAT2)
      clr2 = rd_val_r & `TAI_ST_CLR_MASK;
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      stat1_r <= 8'h00;
      stat2_r <= 8'h00;
    end else begin
      stat1_r <= (stat1_r & ~clr1) | set1;
      stat2_r <= (stat2_r & ~clr2) | set2;
    end
  end

  // Channel masks and the live unmasked alarm cause
  assign ch_mask[0] = consec_r[`TAI_CONSEC_MASK_LOC] |
                      cfg_r[`TAI_CFG_MASK_ALL];
  assign ch_mask[1] = cfg_r[`TAI_CFG_MASK_R1] |
                      cfg_r[`TAI_CFG_MASK_ALL];
  assign ch_mask[2] = cfg_r[`TAI_CFG_MASK_R2] |
                      cfg_r[`TAI_CFG_MASK_ALL];
  assign cond_now = |((hi_lvl_r | lo_lvl_r) & ~ch_mask) |
                    (|open_r & ~cfg_r[`TAI_CFG_MASK_ALL]);
  assign stat_any = (|stat1_r) | (|stat2_r);

  // Latched alarm with three-way release
  always @(posedge ref_clk) begin
    if (srst) begin
      alert_r <= 1'b0;
      ara_served_r <= 1'b0;
    end else begin
      if ((eval_d_r || conv_start_r) && cond_now && !alert_r) begin
        alert_r <= 1'b1;
        ara_served_r <= 1'b0;
      end else begin
        if (rd_stb_r && rd_ara_r) ara_served_r <= 1'b1;
        if (alert_r && ara_served_r && !cond_now && !stat_any)
          alert_r <= 1'b0;
      end
    end
  end

  // Open-drain pins, driven low when the enable is high
  always @(posedge ref_clk) begin
    if (srst) begin
      limit_alarm_out_r <= 1'b0;
      limit_alarm_oe_r <= 1'b0;
      failsafe_over_temp_out_r <= 1'b0;
      failsafe_over_temp_oe_r <= 1'b0;
    end else begin
      limit_alarm_out_r <= 1'b0;
      failsafe_over_temp_out_r <= 1'b0;
      limit_alarm_oe_r <= cfg_r[`TAI_CFG_SEC_MODE] ?
                          |sec_act : alert_r;
      failsafe_over_temp_oe_r <= |fs_act;
    end
  end
endmodule // tai_alarm

//--- tb/tai_alarm_checker.sv
`timescale 1ns/1ps
// Port-level checks of the alarm block
module tai_alarm_checker #(
  parameter CONV_PERIOD = 100000
) (
  input wire ref_clk,
  input wire srst,
  input wire smb_scl_in,
  input wire smb_sda_in,
  input wire smb_sda_out_r,
  input wire smb_sda_oe_r,
  input wire conv_done,
  input wire [7:0] conv_temp_loc,
  input wire [7:0] conv_temp_r1,
  input wire [7:0] conv_temp_r2,
  input wire r1_open_cmp,
  input wire r2_open_cmp,
  input wire conv_start_r,
  input wire conv_abort_r,
  input wire standby_r,
  input wire limit_alarm_out_r,
  input wire limit_alarm_oe_r,
  input wire failsafe_over_temp_out_r,
  input wire failsafe_over_temp_oe_r
);
  reg [3:0] ev_r;
  reg [3:0] dn_r;
  reg [19:0] gap_r;
  reg busy_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // Cycles since converter events, idle gap and busy window
  always @(posedge ref_clk) begin
    if (srst) begin
      ev_r <= 4'hF;
      dn_r <= 4'hF;
      gap_r <= 20'h00000;
      busy_r <= 1'b0;
    end else begin
      ev_r <= (conv_done | conv_start_r) ? 4'h0 : ev_r + 4'(ev_r != 4'hF);
      dn_r <= conv_done ? 4'h0 : dn_r + 4'(dn_r != 4'hF);
      gap_r <= (conv_start_r | standby_r | busy_r) ? 20'h0 : gap_r + 20'h1;
      busy_r <= conv_start_r | (busy_r & !conv_done & !conv_abort_r);
    end
  end
  a_start_one_cycle: assert property (conv_start_r |=> !conv_start_r)
    else $error("conversion start wider than one cycle");
  a_abort_in_standby: assert property (conv_abort_r |-> ##[0:2] standby_r)
    else $error("abort without standby");
  a_abort_when_busy: assert property (conv_abort_r |-> busy_r)
    else $error("abort with no conversion running");
  a_fs_set_eval: assert property (
    $rose(failsafe_over_temp_oe_r) |-> dn_r <= 4'h4)
    else $error("fail-safe set away from a result");
  a_fs_release_eval: assert property (
    $fell(failsafe_over_temp_oe_r) |-> dn_r <= 4'h4)
    else $error("fail-safe released away from a result");
  a_alarm_set_eval: assert property (
    $rose(limit_alarm_oe_r) |-> ev_r <= 4'h4)
    else $error("alarm set away from a conversion event");
  a_sda_low_phase: assert property (
    $changed(smb_sda_oe_r) |-> !smb_scl_in)
    else $error("data line changed while bus clock high");
  a_periodic_gap: assert property (gap_r <= CONV_PERIOD + 8)
    else $error("periodic conversion missing");
  a_open_drain_pins: assert property (!limit_alarm_out_r &&
    !failsafe_over_temp_out_r && !smb_sda_out_r)
    else $error("open-drain pin driven high");
  c_fs_set: cover property ($rose(failsafe_over_temp_oe_r));
  c_alarm_release: cover property ($fell(limit_alarm_oe_r));
  c_abort: cover property (conv_abort_r);
  c_one_shot: cover property (standby_r && conv_start_r);
endmodule // tai_alarm_checker

//--- tb/tai_smb_host.sv
`timescale 1ns/1ps
// Bus host: clock idles high outside frames, 160 ns bit time
module tai_smb_host (
  input wire ref_clk,
  output logic scl,
  output logic sda_low,
  input wire sda
);
  // Idle bus at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One bit: data set in the low phase, sampled at end of high phase
  task automatic bitx(input logic v, output logic r);
    repeat (4) @(posedge ref_clk);
    sda_low <= !v;
    repeat (4) @(posedge ref_clk);
    scl <= 1'b1;
    repeat (8) @(posedge ref_clk);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start;
    repeat (8) @(posedge ref_clk);
    sda_low <= 1'b1;
    repeat (8) @(posedge ref_clk);
    scl <= 1'b0;
  endtask
  task automatic stop;
    repeat (4) @(posedge ref_clk);
    sda_low <= 1'b1;
    repeat (4) @(posedge ref_clk);
    scl <= 1'b1;
    repeat (8) @(posedge ref_clk);
    sda_low <= 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // Reads one byte and ends it with no acknowledge
  task automatic rbyte(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(1'b1, r);
  endtask
  // Write: write pointer, then data
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic a;
    start;
    wbyte(8'h98, a);
    wbyte(p, a);
    wbyte(d, a);
    stop;
  endtask
  // Read: load read pointer, then one byte
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic a;
    start;
    wbyte(8'h98, a);
    wbyte(p, a);
    stop;
    start;
    wbyte(8'h99, a);
    rbyte(d);
    stop;
  endtask
  // Alert response read
  task automatic ara(output logic ack, output logic [7:0] d);
    d = 8'h00;
    start;
    wbyte(8'h19, ack);
    if (ack) rbyte(d);
    stop;
  endtask
endmodule // tai_smb_host

//--- tb/tai_alarm_tb.sv
`timescale 1ns/1ps
module tai_alarm_tb;
  logic ref_clk, srst, done, op1, op2, pend, a;
  logic [7:0] b, h, hy;
  logic [7:0] t [3];
  logic [7:0] rv_p [7] = '{8'h03, 8'h22, 8'h21, 8'h38, 8'h39, 8'h09, 8'h7E};
  logic [7:0] rv_e [7] = '{8'h00, 8'h00, 8'h0A, 8'h55, 8'h55, 8'h00, 8'h00};
  logic [7:0] mk_p [4] = '{8'h22, 8'h09, 8'h09, 8'h09};
  logic [7:0] mk_v [4] = '{8'h20, 8'h02, 8'h01, 8'h80};
  wire scl, sda_low, sda_oe, cst, cab, stb, alm, fs, sda;
  int err_total, samples_checked, seed, lat, cnt, n_start, n_done, k, c, m;
  // Data line: pull-up, low when any party pulls
  assign sda = !(sda_low || sda_oe);
  tai_alarm #(.CONV_PERIOD(50)) i_dut (
    .ref_clk(ref_clk), .srst(srst), .smb_scl_in(scl), .smb_sda_in(sda),
    .smb_sda_out_r(), .smb_sda_oe_r(sda_oe), .conv_done(done),
    .conv_temp_loc(t[0]), .conv_temp_r1(t[1]), .conv_temp_r2(t[2]),
    .r1_open_cmp(op1), .r2_open_cmp(op2), .conv_start_r(cst),
    .conv_abort_r(cab), .standby_r(stb), .limit_alarm_out_r(),
    .limit_alarm_oe_r(alm), .failsafe_over_temp_out_r(),
    .failsafe_over_temp_oe_r(fs));
  tai_smb_host i_host (.ref_clk(ref_clk), .scl(scl), .sda_low(sda_low),
    .sda(sda));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Converter stand-in: random latency, work dropped on abort
  always @(posedge ref_clk) begin
    done <= 1'b0;
    if (cst) begin
      pend <= 1'b1;
      cnt <= lat;
      n_start <= n_start + 1;
    end else if (cab || srst) begin
      pend <= 1'b0;
    end else if (pend && cnt == 0) begin
      pend <= 1'b0;
      done <= 1'b1;
      n_done <= n_done + 1;
    end else if (pend) begin
      cnt <= cnt - 1;
    end
  end
  task automatic chk(input string nm, input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wdone(input int tg);
    for (int i = 0; i < 3000 && n_done < tg; i++) @(posedge ref_clk);
    if (n_done < tg) begin
      chk("conv_wait", 8'h00, 8'h01);
      report_and_stop;
    end
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic do_rst;
    srst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // Status bit of a high (or local low) event per channel
  function automatic int st_bit(input int ch, input int lo);
    return lo ? 5 : (ch == 0 ? 6 : 4);
  endfunction
  initial begin
    seed = 32'hd260;
    err_total = 0;
    samples_checked = 0;
    srst = 1'b1;
    {done, pend, op1, op2} = 4'h0;
    {n_start, n_done, cnt, lat} = {32'd0, 32'd0, 32'd0, 32'd4};
    foreach (t[i]) t[i] = 8'h30;
    do_rst;
    // Reset values and the split pointer pair
    foreach (rv_p[i]) begin
      i_host.rd(rv_p[i], b);
      chk("reset_value", b, rv_e[i]);
    end
    i_host.wr(8'h09, 8'h83);
    i_host.wr(8'h03, 8'h00);
    i_host.rd(8'h03, b);
    chk("cfg_pair", b, 8'h83);
    // Fail-safe under full masking, default then random hysteresis
    h = 8'h01 + 8'({$random(seed)} % 12);
    for (c = 0; c < 2; c++) begin
      hy = c ? h : 8'h0A;
      m = c ? 2 : 0;
      if (c) i_host.wr(8'h21, h);
      t[m] <= 8'h56;
      wdone(n_done + 2);
      chk("fs_set", 8'(fs), 8'h01);
      t[m] <= 8'h55 - hy + 8'h01;
      wdone(n_done + 2);
      chk("fs_hold", 8'(fs), 8'h01);
      t[m] <= 8'h55 - hy;
      wdone(n_done + 2);
      chk("fs_release", 8'(fs), 8'h00);
      chk("alarm_masked", 8'(alm), 8'h00);
    end
    // Alarm per channel, with and without its mask, then serviced
    for (c = 0; c < 5; c++) begin
      for (m = 0; m < (c == 4 ? 1 : 2); m++) begin
        do_rst;
        lat = 2 + {$random(seed)} % 16;
        k = (c == 3) ? {$random(seed)} % 3 : (c == 4 ? 0 : c);
        if (m) i_host.wr(mk_p[c], mk_v[c]);
        if (c == 4) i_host.wr(8'h34, 8'h20);
        t[k] <= (c == 4) ? 8'h20 : 8'h56 + 8'({$random(seed)} % 8);
        wdone(n_done + 2);
        chk("alarm_set", 8'(alm), 8'(!m));
        t[k] <= 8'h30;
        if (!m) begin
          wdone(n_done + 2);
          i_host.rd(k == 2 ? 8'h23 : 8'h02, b);
          chk("status_bit", 8'(b[st_bit(k, c == 4)]), 8'h01);
          i_host.rd(k == 2 ? 8'h02 : 8'h23, b);
          chk("alarm_held", 8'(alm), 8'h01);
          i_host.ara(a, b);
          chk("ara_ack", 8'(a), 8'h01);
          chk("ara_addr", b, 8'h99);
          repeat (8) @(posedge ref_clk);
          chk("alarm_clear", 8'(alm), 8'h00);
          i_host.ara(a, b);
          chk("ara_idle", 8'(a), 8'h00);
        end
      end
    end
    // Open remote diodes: flags, alarm and a frozen result
    do_rst;
    wdone(n_done + 1);
    op1 <= 1'b1;
    t[1] <= 8'h44;
    wdone(n_done + 2);
    i_host.rd(8'h02, b);
    chk("r1_open", 8'(b[2]), 8'h01);
    chk("open_alarm", 8'(alm), 8'h01);
    i_host.rd(8'h41, b);
    chk("r1_result", b, 8'h30);
    op2 <= 1'b1;
    wdone(n_done + 2);
    i_host.rd(8'h23, b);
    chk("r2_open", 8'(b[2]), 8'h01);
    // Standby with a conversion running; pins not judged here
    op1 <= 1'b0;
    op2 <= 1'b0;
    do_rst;
    // Secondary over-temp on the alarm pin: unmaskable, with hysteresis
    i_host.wr(8'h09, 8'hA0);
    for (c = 0; c < 3; c++) begin
      t[1] <= (c == 0) ? 8'h56 : 8'h4D - 8'(c);
      wdone(n_done + 2);
      chk("secondary", 8'(alm), 8'(c < 2));
    end
    lat = 200;
    wdone(n_done + 1);
    i_host.wr(8'h09, 8'h40);
    repeat (4) @(posedge ref_clk);
    k = n_start;
    t[0] <= 8'h50;
    repeat (300) @(posedge ref_clk);
    chk("standby_starts", 8'(n_start - k), 8'h00);
    i_host.rd(8'h40, b);
    chk("standby_result", b, 8'h30);
    i_host.wr(8'h30, 8'h3A);
    i_host.rd(8'h30, b);
    chk("standby_limit", b, 8'h3A);
    lat = 4;
    k = n_done + 1;
    i_host.wr(8'h0F, 8'($random(seed)));
    wdone(k);
    i_host.rd(8'h40, b);
    chk("oneshot_result", b, 8'h50);
    k = n_start;
    repeat (300) @(posedge ref_clk);
    chk("oneshot_once", 8'(n_start - k), 8'h00);
    i_host.wr(8'h09, 8'h00);
    k = n_start;
    for (c = 0; c < 200 && n_start == k; c++) @(posedge ref_clk);
    chk("resume", 8'(n_start != k), 8'h01);
    report_and_stop;
  end
endmodule // tai_alarm_tb

bind tai_alarm tai_alarm_checker #(.CONV_PERIOD(CONV_PERIOD)) i_chk (
  .ref_clk(ref_clk), .srst(srst), .smb_scl_in(smb_scl_in),
  .smb_sda_in(smb_sda_in), .smb_sda_out_r(smb_sda_out_r),
  .smb_sda_oe_r(smb_sda_oe_r), .conv_done(conv_done),
  .conv_temp_loc(conv_temp_loc), .conv_temp_r1(conv_temp_r1),
  .conv_temp_r2(conv_temp_r2), .r1_open_cmp(r1_open_cmp),
  .r2_open_cmp(r2_open_cmp), .conv_start_r(conv_start_r),
  .conv_abort_r(conv_abort_r), .standby_r(standby_r),
  .limit_alarm_out_r(limit_alarm_out_r), .limit_alarm_oe_r(limit_alarm_oe_r),
  .failsafe_over_temp_out_r(failsafe_over_temp_out_r),
  .failsafe_over_temp_oe_r(failsafe_over_temp_oe_r));
